// file: pkg/rslc_pkg.sv
// What this block does
// - Three-bit code picks one of eight reset delays.
// - Record trigger starts logging, always reads zero.
// - Kind select: power up, down, wake, doze.
// - Compare logged order with expected order afterwards.
// - Timestamp release clears ready and overwritten flags unless auto-overwrite.
// - Power-up release clears its flags unless auto-overwrite.
// - Power-down release clears its flags unless auto-overwrite.
// - Wake release clears its flags unless auto-overwrite.
// - Doze release clears its flags unless auto-overwrite.
// - Activate rise masks selected channels' three interrupts.
// - Activate fall masks selected channels' three interrupts.
// - Sleep rise masks selected channels' three interrupts.
// - Sleep fall masks selected channels' three interrupts.
// - Timeout expiry releases every auto-mask.
// - Timeout equals programmed sixteen-bit value plus one ms.
// - Timeout reaches beyond four seconds, low byte alone 256ms.
// - Tag pulse is 50 us plus 10 us per step.
// - Up tagging bit picks off or undervoltage threshold.
// - Down tagging bit picks off or undervoltage threshold.
// - Each channel order compared with eight-bit expected value.
package rslc_pkg;

  // ***********************************************************
  // Register indices; byte address is four times the index.
  // ***********************************************************
  localparam logic [7:0] IDX_RESET_DELAY = 8'h9f;
  localparam logic [7:0] IDX_RECORD_CTRL = 8'ha0;
  localparam logic [7:0] IDX_POWER_ON_MASK = 8'ha1;
  localparam logic [7:0] IDX_POWER_OFF_MASK = 8'ha2;
  localparam logic [7:0] IDX_SLEEP_EXIT_MASK = 8'ha3;
  localparam logic [7:0] IDX_SLEEP_ENTRY_MASK = 8'ha4;
  localparam logic [7:0] IDX_TIMEOUT_HIGH = 8'ha5;
  localparam logic [7:0] IDX_TIMEOUT_LOW = 8'ha6;
  localparam logic [7:0] IDX_TAG_WIDTH = 8'ha7;
  localparam logic [7:0] IDX_UP_THRESHOLD = 8'ha8;
  localparam logic [7:0] IDX_DOWN_THRESHOLD = 8'ha9;
  localparam logic [7:0] IDX_LOG_READY = 8'haa;
  localparam logic [7:0] IDX_LOG_OVERWRITTEN = 8'hab;
  localparam logic [7:0] IDX_OVERWRITE_CTRL = 8'hac;
  localparam logic [7:0] IDX_ORDER_FAULT = 8'had;

  // ***********************************************************
  // Field positions and reset values.
  // ***********************************************************
  localparam int REC_TRIGGER_BIT = 7;
  localparam int KIND_MSB = 6;
  localparam int KIND_LSB = 5;
  localparam int TS_RELEASE_BIT = 4;
  localparam int TS_AUTO_OW_BIT = 0;
  localparam int ORDER_AUTO_OW_BIT = 1;
  localparam logic [2:0] RESET_DELAY_RST = 3'h2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] AUTO_MASK_RST = 8'hff;
  localparam logic [7:0] TIMEOUT_RST = 8'h00;
  localparam logic [7:0] TAG_WIDTH_RST = 8'h00;
  localparam logic [7:0] UP_THRESHOLD_RST = 8'h1f;
  localparam logic [7:0] DOWN_THRESHOLD_RST = 8'h00;
  localparam logic [1:0] OVERWRITE_CTRL_RST = 2'h0;

  // ***********************************************************
  // Timing.
  // ***********************************************************
  localparam int MCLK_HZ = 40000000;
  localparam int MS_CYCLES = MCLK_HZ / 1000;
  localparam int US_CYCLES = MCLK_HZ / 1000000;
  localparam int TAG_BASE_US = 50;
  localparam int TAG_STEP_US = 10;

  typedef enum logic [1:0] {
    RSLC_POWER_UP = 2'h0,
    RSLC_POWER_DOWN = 2'h1,
    RSLC_WAKE = 2'h2,
    RSLC_DOZE = 2'h3
  } rslc_kind_t;

  typedef struct packed {
    logic [7:0] slow_under_irq_enable;
    logic [7:0] fast_under_irq_enable;
    logic [7:0] fast_over_irq_enable;
  } rslc_irq_en_t;

  function automatic logic [17:0] rslc_reset_delay_us(input logic [2:0] code);
    logic [17:0] us;
    us = 18'h0;
    unique case (code)
      3'h0: us = 18'd200;
      3'h1: us = 18'd1000;
      3'h2: us = 18'd10000;
      3'h3: us = 18'd16000;
      3'h4: us = 18'd20000;
      3'h5: us = 18'd70000;
      3'h6: us = 18'd100000;
      3'h7: us = 18'd200000;
    endcase
    return us;
  endfunction

endpackage

// file: verilog/rslc_top.sv
module rslc_top
  import rslc_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int ADDR_W = 12,
  parameter int MS_TICK_CYCLES = MS_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic activate_input_i,
  input wire logic sleep_input_i,
  input wire logic [3:0] log_done_i,
  input wire logic timestamp_done_i,
  input wire logic [CHANNELS-1:0][7:0] order_log_i,
  input wire logic [CHANNELS-1:0][7:0] expected_order_i,
  input wire rslc_irq_en_t irq_en_i,
  output rslc_irq_en_t irq_en_o,
  output logic auto_mask_active_o,
  output logic recording_o,
  output logic [1:0] record_kind_o,
  output logic [CHANNELS-1:0] order_fault_o,
  output logic [CHANNELS-1:0] tag_use_uv_o,
  output logic [16:0] tag_pulse_cycles_o,
  output logic [17:0] reset_delay_us_o
);

  if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
    $error("CHANNELS must be 1 to 8");
  end
  if (ADDR_W < 10) begin : g_bad_addr
    $error("ADDR_W must be at least 10");
  end
  if (MS_TICK_CYCLES < 2) begin : g_bad_tick
    $error("MS_TICK_CYCLES must be at least 2");
  end

  localparam int DIV_W = $clog2(MS_TICK_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_TICK_CYCLES - 1);

  typedef enum {
    REC_IDLE,
    REC_ARMED,
    REC_LOGGING
  } rslc_rec_state_t;

  // ***********************************************************
  // Registers.
  // ***********************************************************
  logic [2:0] reset_delay_code;
  logic [1:0] sequence_kind_select;
  logic [7:0] power_on_auto_mask;
  logic [7:0] power_off_auto_mask;
  logic [7:0] sleep_exit_auto_mask;
  logic [7:0] sleep_entry_auto_mask;
  logic [7:0] sequence_timeout_high;
  logic [7:0] sequence_timeout_low;
  logic [7:0] tag_pulse_width;
  logic [7:0] up_tag_threshold_select;
  logic [7:0] down_tag_threshold_select;
  logic timestamp_auto_overwrite;
  logic order_log_auto_overwrite;
  logic [3:0] log_ready;
  logic [3:0] log_overwritten;
  logic timestamp_ready_flag;
  logic timestamp_overwritten_flag;

  // ***********************************************************
  // Wishbone slave.
  // ***********************************************************
  logic [7:0] bus_idx;
  logic bus_hit;
  logic wr_commit;
  logic [7:0] wr_byte;
  logic [7:0] next_rdata;

  assign bus_idx = wb_adr_i[9:2];
  assign bus_hit = (wb_adr_i >> 10) == '0;
  // A write lands on the edge where the master sees ack, so it is taken exactly once.
  assign wr_commit = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && bus_hit;
  assign wr_byte = wb_dat_i[7:0];

  always_comb begin
    next_rdata = 8'h00;
    if (bus_hit) begin
      unique case (bus_idx)
        IDX_RESET_DELAY: next_rdata = {5'h00, reset_delay_code};
        IDX_RECORD_CTRL: next_rdata = {1'b0, sequence_kind_select, 5'h00};
        IDX_POWER_ON_MASK: next_rdata = power_on_auto_mask;
        IDX_POWER_OFF_MASK: next_rdata = power_off_auto_mask;
        IDX_SLEEP_EXIT_MASK: next_rdata = sleep_exit_auto_mask;
        IDX_SLEEP_ENTRY_MASK: next_rdata = sleep_entry_auto_mask;
        IDX_TIMEOUT_HIGH: next_rdata = sequence_timeout_high;
        IDX_TIMEOUT_LOW: next_rdata = sequence_timeout_low;
        IDX_TAG_WIDTH: next_rdata = tag_pulse_width;
        IDX_UP_THRESHOLD: next_rdata = up_tag_threshold_select;
        IDX_DOWN_THRESHOLD: next_rdata = down_tag_threshold_select;
        IDX_LOG_READY: next_rdata = {3'h0, timestamp_ready_flag, log_ready[0], log_ready[1],
                                     log_ready[2], log_ready[3]};
        IDX_LOG_OVERWRITTEN: next_rdata = {3'h0, timestamp_overwritten_flag, log_overwritten[0],
                                           log_overwritten[1], log_overwritten[2],
                                           log_overwritten[3]};
        IDX_OVERWRITE_CTRL: next_rdata = {6'h00, order_log_auto_overwrite,
                                          timestamp_auto_overwrite};
        IDX_ORDER_FAULT: next_rdata = 8'(order_fault_o);
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= {24'h00_0000, next_rdata};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      reset_delay_code <= RESET_DELAY_RST;
      sequence_kind_select <= CTRL_RST[KIND_MSB:KIND_LSB];
      power_on_auto_mask <= AUTO_MASK_RST;
      power_off_auto_mask <= AUTO_MASK_RST;
      sleep_exit_auto_mask <= AUTO_MASK_RST;
      sleep_entry_auto_mask <= AUTO_MASK_RST;
      sequence_timeout_high <= TIMEOUT_RST;
      sequence_timeout_low <= TIMEOUT_RST;
      tag_pulse_width <= TAG_WIDTH_RST;
      up_tag_threshold_select <= UP_THRESHOLD_RST;
      down_tag_threshold_select <= DOWN_THRESHOLD_RST;
      timestamp_auto_overwrite <= OVERWRITE_CTRL_RST[TS_AUTO_OW_BIT];
      order_log_auto_overwrite <= OVERWRITE_CTRL_RST[ORDER_AUTO_OW_BIT];
    end else if (wr_commit) begin
      unique case (bus_idx)
        IDX_RESET_DELAY: reset_delay_code <= wr_byte[2:0];
        IDX_RECORD_CTRL: sequence_kind_select <= wr_byte[KIND_MSB:KIND_LSB];
        IDX_POWER_ON_MASK: power_on_auto_mask <= wr_byte;
        IDX_POWER_OFF_MASK: power_off_auto_mask <= wr_byte;
        IDX_SLEEP_EXIT_MASK: sleep_exit_auto_mask <= wr_byte;
        IDX_SLEEP_ENTRY_MASK: sleep_entry_auto_mask <= wr_byte;
        IDX_TIMEOUT_HIGH: sequence_timeout_high <= wr_byte;
        IDX_TIMEOUT_LOW: sequence_timeout_low <= wr_byte;
        IDX_TAG_WIDTH: tag_pulse_width <= wr_byte;
        IDX_UP_THRESHOLD: up_tag_threshold_select <= wr_byte;
        IDX_DOWN_THRESHOLD: down_tag_threshold_select <= wr_byte;
        IDX_OVERWRITE_CTRL: begin
          timestamp_auto_overwrite <= wr_byte[TS_AUTO_OW_BIT];
          order_log_auto_overwrite <= wr_byte[ORDER_AUTO_OW_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ***********************************************************
  // Activate and sleep pins: synchroniser and edge detect.
  // ***********************************************************
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] pin_prev;
  logic [3:0] edge_hit;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
      pin_prev <= 2'h0;
    end else begin
      pin_meta <= {sleep_input_i, activate_input_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Indexed by kind code: activate rise, activate fall, sleep rise, sleep fall.
  assign edge_hit[RSLC_POWER_UP] = pin_sync[0] && !pin_prev[0];
  assign edge_hit[RSLC_POWER_DOWN] = !pin_sync[0] && pin_prev[0];
  assign edge_hit[RSLC_WAKE] = pin_sync[1] && !pin_prev[1];
  assign edge_hit[RSLC_DOZE] = !pin_sync[1] && pin_prev[1];

  // ***********************************************************
  // Auto-mask and sequence timeout.
  // ***********************************************************
  logic [DIV_W-1:0] ms_div;
  logic [15:0] ms_count;
  logic ms_tick;
  logic any_edge;
  logic timeout_expired;
  logic [7:0] mask_set;
  logic [7:0] mask_active;

  assign ms_tick = ms_div == DIV_LAST;
  assign any_edge = |edge_hit;
  // Programmed value n expires on the (n+1)-th millisecond tick after the edge.
  assign timeout_expired = auto_mask_active_o && ms_tick &&
                           ms_count == {sequence_timeout_high, sequence_timeout_low};

  always_comb begin
    mask_set = 8'h00;
    if (edge_hit[RSLC_POWER_UP]) begin
      mask_set = mask_set | power_on_auto_mask;
    end
    if (edge_hit[RSLC_POWER_DOWN]) begin
      mask_set = mask_set | power_off_auto_mask;
    end
    if (edge_hit[RSLC_WAKE]) begin
      mask_set = mask_set | sleep_exit_auto_mask;
    end
    if (edge_hit[RSLC_DOZE]) begin
      mask_set = mask_set | sleep_entry_auto_mask;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ms_div <= '0;
      ms_count <= 16'h0000;
      mask_active <= 8'h00;
      auto_mask_active_o <= 1'b0;
    end else if (any_edge) begin
      // The divider restarts too, so the first millisecond is a whole one.
      ms_div <= '0;
      ms_count <= 16'h0000;
      mask_active <= mask_active | mask_set;
      auto_mask_active_o <= 1'b1;
    end else if (timeout_expired) begin
      ms_div <= '0;
      ms_count <= 16'h0000;
      mask_active <= 8'h00;
      auto_mask_active_o <= 1'b0;
    end else if (auto_mask_active_o) begin
      if (ms_tick) begin
        ms_div <= '0;
        ms_count <= ms_count + 16'h0001;
      end else begin
        ms_div <= ms_div + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      irq_en_o <= '0;
    end else begin
      irq_en_o.slow_under_irq_enable <= irq_en_i.slow_under_irq_enable & ~mask_active;
      irq_en_o.fast_under_irq_enable <= irq_en_i.fast_under_irq_enable & ~mask_active;
      irq_en_o.fast_over_irq_enable <= irq_en_i.fast_over_irq_enable & ~mask_active;
    end
  end

  // ***********************************************************
  // Recording and order comparison.
  // ***********************************************************
  logic trigger_write;
  logic [CHANNELS-1:0] order_mismatch;
  rslc_rec_state_t rec_state;

  assign trigger_write = wr_commit && bus_idx == IDX_RECORD_CTRL && wr_byte[REC_TRIGGER_BIT];

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_compare
    assign order_mismatch[ch] = order_log_i[ch] != expected_order_i[ch];
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rec_state <= REC_IDLE;
      recording_o <= 1'b0;
      record_kind_o <= 2'h0;
      order_fault_o <= '0;
    end else if (trigger_write) begin
      rec_state <= REC_ARMED;
      recording_o <= 1'b0;
      record_kind_o <= wr_byte[KIND_MSB:KIND_LSB];
    end else begin
      unique case (rec_state)
        REC_IDLE: begin
        end
        REC_ARMED: begin
          if (edge_hit[record_kind_o]) begin
            rec_state <= REC_LOGGING;
            recording_o <= 1'b1;
          end
        end
        REC_LOGGING: begin
          if (log_done_i[record_kind_o]) begin
            rec_state <= REC_IDLE;
            recording_o <= 1'b0;
            order_fault_o <= order_mismatch;
          end
        end
      endcase
    end
  end

  // ***********************************************************
  // Ready and overwritten flags with host release.
  // ***********************************************************
  logic ctrl_write;
  logic [3:0] log_release;
  logic ts_release;

  assign ctrl_write = wr_commit && bus_idx == IDX_RECORD_CTRL;
  assign ts_release = ctrl_write && wr_byte[TS_RELEASE_BIT] && !timestamp_auto_overwrite;
  assign log_release[RSLC_POWER_UP] = ctrl_write && wr_byte[3] && !order_log_auto_overwrite;
  assign log_release[RSLC_POWER_DOWN] = ctrl_write && wr_byte[2] && !order_log_auto_overwrite;
  assign log_release[RSLC_WAKE] = ctrl_write && wr_byte[1] && !order_log_auto_overwrite;
  assign log_release[RSLC_DOZE] = ctrl_write && wr_byte[0] && !order_log_auto_overwrite;

  // A new log in the release cycle wins, so it is never lost.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      log_ready <= 4'h0;
      log_overwritten <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (log_done_i[k]) begin
          log_ready[k] <= 1'b1;
          if (log_ready[k] && !log_release[k]) begin
            log_overwritten[k] <= 1'b1;
          end
        end else if (log_release[k]) begin
          log_ready[k] <= 1'b0;
          log_overwritten[k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      timestamp_ready_flag <= 1'b0;
      timestamp_overwritten_flag <= 1'b0;
    end else if (timestamp_done_i) begin
      timestamp_ready_flag <= 1'b1;
      if (timestamp_ready_flag && !ts_release) begin
        timestamp_overwritten_flag <= 1'b1;
      end
    end else if (ts_release) begin
      timestamp_ready_flag <= 1'b0;
      timestamp_overwritten_flag <= 1'b0;
    end
  end

  // ***********************************************************
  // Tagging, threshold choice and reset delay.
  // ***********************************************************
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tag_use_uv_o <= UP_THRESHOLD_RST[CHANNELS-1:0];
      tag_pulse_cycles_o <= 17'h0_0000;
      reset_delay_us_o <= 18'h0_0000;
    end else begin
      if (edge_hit[RSLC_POWER_UP] || edge_hit[RSLC_WAKE]) begin
        tag_use_uv_o <= up_tag_threshold_select[CHANNELS-1:0];
      end else if (edge_hit[RSLC_POWER_DOWN] || edge_hit[RSLC_DOZE]) begin
        tag_use_uv_o <= down_tag_threshold_select[CHANNELS-1:0];
      end
      tag_pulse_cycles_o <= 17'((TAG_BASE_US + TAG_STEP_US * int'(tag_pulse_width))
                                * US_CYCLES);
      reset_delay_us_o <= rslc_reset_delay_us(reset_delay_code);
    end
  end

endmodule

// file: verification/rslc_monitor.sv
module rslc_monitor
  import rslc_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int ADDR_W = 12,
  parameter int MS_TICK_CYCLES = MS_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire rslc_irq_en_t irq_en_i,
  input wire rslc_irq_en_t irq_en_o,
  input wire logic auto_mask_active_o,
  input wire logic [1:0] record_kind_o,
  input wire logic [16:0] tag_pulse_cycles_o,
  input wire logic [17:0] reset_delay_us_o
);
  // ***********************************************************
  // Register side effects and auto-mask timing at the ports.
  // ***********************************************************
  localparam int DLY_US [8] = '{200, 1000, 10000, 16000, 20000, 70000, 100000, 200000};
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  // The release bound holds only for the short tick used in simulation.
  sequence s_acc(w, idx);
    wb_ack_o && wb_we_i == w && wb_adr_i == ADDR_W'({idx, 2'h0});
  endsequence
  a_ack_on_request:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered after one cycle");
  a_ctrl_reads_zero:
    assert property (s_acc(1'b0, 8'ha0) |-> wb_dat_o[7] == 1'b0 && wb_dat_o[4:0] == 5'h0)
    else $error("trigger or release bit read back as one");
  a_kind_latch:
    assert property (s_acc(1'b1, 8'ha0) ##0 wb_dat_i[7] |-> ##2
      record_kind_o == $past(wb_dat_i[6:5], 2))
    else $error("record kind not taken from trigger write");
  a_delay_code:
    assert property (s_acc(1'b1, 8'h9f) |-> ##2
      reset_delay_us_o == 18'(DLY_US[$past(wb_dat_i[2:0], 2)]))
    else $error("reset delay value does not match code");
  a_tag_width:
    assert property (s_acc(1'b1, 8'ha7) |-> ##2 tag_pulse_cycles_o ==
      17'((TAG_BASE_US + TAG_STEP_US * $past(wb_dat_i[7:0], 2)) * US_CYCLES))
    else $error("tag pulse width wrong");
  a_unmasked_follow:
    assert property (!$past(auto_mask_active_o) && $past(rstn_i) |->
      irq_en_o == $past(irq_en_i))
    else $error("interrupt enable masked while no mask active");
  a_mask_min_hold:
    assert property ($rose(auto_mask_active_o) |-> auto_mask_active_o[*8])
    else $error("auto-mask released too early");
  a_mask_release_bound:
    assert property ($rose(auto_mask_active_o) |-> ##[1:1000] !auto_mask_active_o)
    else $error("auto-mask never released");
endmodule

bind rslc_top rslc_monitor #(.CHANNELS(CHANNELS), .ADDR_W(ADDR_W),
  .MS_TICK_CYCLES(MS_TICK_CYCLES)) u_mon (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_en_i(irq_en_i),
  .irq_en_o(irq_en_o), .auto_mask_active_o(auto_mask_active_o),
  .record_kind_o(record_kind_o), .tag_pulse_cycles_o(tag_pulse_cycles_o),
  .reset_delay_us_o(reset_delay_us_o));

// file: verification/rslc_host_model.sv
module rslc_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [11:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] wdat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***********************************************************
  // Classic single-cycle bus master.
  // ***********************************************************
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 12'h0;
    sel_o = 4'h0;
    wdat_o = 32'h0;
  end
  // Released address and data lines carry the inverse so a slave cannot lean on stale values.
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    sel_o <= 4'h1;
    adr_o <= {2'h0, idx, 2'h0};
    wdat_o <= {24'h0, d};
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = rdat_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    sel_o <= 4'h0;
    adr_o <= ~adr_o;
    wdat_o <= ~wdat_o;
  endtask
endmodule

// file: verification/tb.sv
module tb
  import rslc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 10;
  localparam int DLY_US [8] = '{200, 1000, 10000, 16000, 20000, 70000, 100000, 200000};
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic act = 1'b0;
  logic slp = 1'b0;
  logic ts_done = 1'b0;
  logic [3:0] log_done = 4'h0;
  logic [7:0][7:0] order_log = 64'h0;
  logic [7:0][7:0] exp_order = 64'h0300_0000_0000_0001;
  rslc_irq_en_t irq_in = 24'hf7ef5b;
  rslc_irq_en_t irq_out;
  logic cyc, stb, we, ack, mask_act, rec;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [1:0] rec_kind;
  logic [7:0] fault, tag_uv, q;
  logic [16:0] tag_cyc;
  logic [17:0] dly_us;
  logic [7:0] masks [4] = '{8'h05, 8'h30, 8'hc0, 8'h0a};
  int num_errors = 0;
  int n_tests = 0;
  int hi_cnt = 0;

  rslc_host_model host (.clk_i(mclk), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .wdat_o(wdat));
  rslc_top #(.MS_TICK_CYCLES(MS)) dut (.mclk_i(mclk), .rstn_i(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .activate_input_i(act), .sleep_input_i(slp),
    .log_done_i(log_done), .timestamp_done_i(ts_done), .order_log_i(order_log),
    .expected_order_i(exp_order), .irq_en_i(irq_in), .irq_en_o(irq_out),
    .auto_mask_active_o(mask_act), .recording_o(rec), .record_kind_o(rec_kind),
    .order_fault_o(fault), .tag_use_uv_o(tag_uv), .tag_pulse_cycles_o(tag_cyc),
    .reset_delay_us_o(dly_us));

  always #12.5 mclk = ~mclk;
  // Counts cycles with the mask in force, so restarts need no fork.
  always @(posedge mclk) if (mask_act === 1'b1) hi_cnt <= hi_cnt + 1;

  // ***********************************************************
  // Helpers.
  // ***********************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    host.xfer(1'b0, idx, 8'h00, v);
    chk({24'h0, v}, {24'h0, exp});
  endtask
  task automatic pin_edge(input int k);
    @(posedge mclk);
    if (k < 2) act <= (k == 0);
    else slp <= (k == 2);
  endtask
  task automatic pulse_log(input int k);
    @(posedge mclk);
    order_log <= 64'h1 << (8 * (k + 1));
    log_done[k] <= 1'b1;
    @(posedge mclk);
    log_done <= 4'h0;
  endtask
  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ***********************************************************
  // Scenarios.
  // ***********************************************************
  task automatic t_reset_values();
    logic [7:0] idx [12] = '{8'h9f, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6,
      8'ha7, 8'ha8, 8'ha9, 8'hbf};
    logic [7:0] rv [12] = '{8'h02, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
      8'h00, 8'h1f, 8'h00, 8'h00};
    chk(32'(tag_cyc), 32'd2000);
    chk(32'(dly_us), 32'd10000);
    chk(32'(tag_uv), 32'h1f);
    for (int i = 0; i < 12; i++) rd_chk(idx[i], rv[i]);
    host.xfer(1'b1, 8'ha0, 8'hdf, q);
    rd_chk(8'ha0, 8'h40);
  endtask
  task automatic t_codes();
    logic [7:0] w [4] = '{8'h00, 8'h01, 8'h02, 8'hff};
    for (int c = 0; c < 8; c++) begin
      host.xfer(1'b1, 8'h9f, 8'(c), q);
      repeat (2) @(negedge mclk);
      chk(32'(dly_us), DLY_US[c]);
      rd_chk(8'h9f, 8'(c));
    end
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b1, 8'ha7, w[i], q);
      repeat (2) @(negedge mclk);
      chk(32'(tag_cyc), (50 + 10 * w[i]) * 40);
    end
  endtask
  task automatic t_automask();
    host.xfer(1'b1, 8'ha8, 8'h3c, q);
    host.xfer(1'b1, 8'ha9, 8'hc3, q);
    for (int k = 0; k < 4; k++) host.xfer(1'b1, 8'ha1 + 8'(k), masks[k], q);
    for (int k = 0; k < 4; k++) begin
      host.xfer(1'b1, 8'ha6, 8'(k), q);
      @(negedge mclk);
      hi_cnt = 0;
      pin_edge(k);
      repeat (5) @(negedge mclk);
      chk(32'(irq_out), 32'(irq_in & {3{~masks[k]}}));
      while (mask_act === 1'b1) @(negedge mclk);
      chk(hi_cnt, (k + 1) * MS);
      @(negedge mclk);
      chk(32'(irq_out), 32'(irq_in));
      chk(32'(tag_uv), k[0] ? 32'hc3 : 32'h3c);
    end
  endtask
  task automatic t_restart();
    host.xfer(1'b1, 8'ha6, 8'h00, q);
    @(negedge mclk);
    hi_cnt = 0;
    pin_edge(0);
    repeat (6) @(posedge mclk);
    pin_edge(1);
    repeat (3) @(negedge mclk);
    while (mask_act === 1'b1) @(negedge mclk);
    chk(hi_cnt, 7 + MS);
  endtask
  task automatic t_record();
    for (int k = 0; k < 4; k++) begin
      host.xfer(1'b1, 8'ha0, 8'h80 | 8'(k << 5), q);
      pin_edge(k);
      while (rec !== 1'b1) @(negedge mclk);
      chk(32'(rec_kind), k);
      pulse_log(k);
      repeat (2) @(negedge mclk);
      chk(32'(fault), 32'h81 | (32'h1 << (k + 1)));
      chk(32'(rec), 32'h0);
      rd_chk(8'had, 8'h81 | (8'h1 << (k + 1)));
      rd_chk(8'haa, 8'h1 << (3 - k));
      pulse_log(k);
      rd_chk(8'hab, 8'h1 << (3 - k));
      host.xfer(1'b1, 8'ha0, 8'h1 << (3 - k), q);
      rd_chk(8'haa, 8'h00);
      rd_chk(8'hab, 8'h00);
    end
  endtask
  task automatic t_overwrite();
    host.xfer(1'b1, 8'hac, 8'h03, q);
    rd_chk(8'hac, 8'h03);
    pulse_log(0);
    @(posedge mclk);
    ts_done <= 1'b1;
    @(posedge mclk);
    ts_done <= 1'b0;
    host.xfer(1'b1, 8'ha0, 8'h18, q);
    rd_chk(8'haa, 8'h18);
    host.xfer(1'b1, 8'hac, 8'h00, q);
    host.xfer(1'b1, 8'ha0, 8'h18, q);
    rd_chk(8'haa, 8'h00);
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(negedge mclk);
    t_reset_values();
    t_codes();
    t_automask();
    t_restart();
    t_record();
    t_overwrite();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    close_out();
  end
endmodule
